// [core/nco_defines.svh]
`ifndef NCO_DEFINES_SVH
`define NCO_DEFINES_SVH
// ---------------------------------------------
// register word addresses
// ---------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RDIV 8'h08
// ---------------------------------------------
// per-oscillator groups: addr[7:4], index addr[3:2]
// ---------------------------------------------
`define GRP_FREQ_A 4'h1
`define GRP_FREQ_B 4'h2
`define GRP_PHASE_A 4'h3
`define GRP_PHASE_B 4'h4
// ---------------------------------------------
// control field positions
// ---------------------------------------------
`define CTRL_SRC_BIT 0
`define CTRL_SEL_A_LSB 1
`define CTRL_SEL_B_LSB 3
`define CTRL_ILA_BIT 5
`define CTRL_NEXT_BIT 6
`define CTRL_LINK_BIT 7
// ---------------------------------------------
// status field positions
// ---------------------------------------------
`define STAT_NONDET_BIT 4
`define STAT_ARMED_BIT 5
// ---------------------------------------------
// reset values and fixed constants
// ---------------------------------------------
`define CTRL_RESET 8'h00
`define RDIV_RESET 16'h0000
`define RDIV_BASIC 16'h0000
`define RAT_SHIFT 26
`define RAT_HALF 48'h0000_0200_0000
`define PHASE_PAD 16'h0000
`endif

// [core/nco_pkg.sv]
package nco_pkg;
  typedef logic [31:0] word_type;
  typedef logic [1:0] sel_type;
  // software control bits
  typedef struct packed {
    logic link_en;
    logic sync_next;
    logic sync_ila;
    sel_type sel_b;
    sel_type sel_a;
    logic src_pins;
  } ctrl_type;
  // per-channel frequency and phase settings
  typedef struct packed {
    logic [3:0][31:0] freq;
    logic [3:0][15:0] phase;
  } chan_cfg_type;
  // one bank of four running accumulators
  typedef struct packed {
    logic [3:0][31:0] acc;
    logic [3:0][15:0] rem;
  } bank_state_type;
  // sync-pin resynchronisation machine
  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_WAIT_LOW = 3'b010,
    SYNC_WAIT_HIGH = 3'b100
  } sync_state_type;
  // whole state of the top module
  typedef struct packed {
    ctrl_type ctrl;
    logic [15:0] rdiv;
    chan_cfg_type cfg_a;
    chan_cfg_type cfg_b;
    sel_type act_a;
    sel_type act_b;
    sel_type pin_a_s1;
    sel_type pin_a_s2;
    sel_type pin_b_s1;
    sel_type pin_b_s2;
    logic sync_s1;
    logic sync_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_prev;
    sync_state_type fsm;
    logic nondet;
    logic resync;
    word_type rdata;
    word_type phase_a;
    word_type phase_b;
  } top_state_type;
endpackage

// [core/nco_bank.sv]
`timescale 1ns/1ns
`include "nco_defines.svh"
// four free-running phase accumulators for one channel
module nco_bank
  import nco_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [3:0][31:0] freq_in,
  input wire logic [15:0] rdiv_in,
  input wire logic resync_in,
  output logic [3:0][31:0] acc_out
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  bank_state_type st; // registered accumulators
  bank_state_type next_st; // next value
  // ---------------------------------------------
  // rational step: {quotient, remainder}
  // ---------------------------------------------
  // recovers the step count from the word, then the exact ratio
  function automatic logic [47:0] rat_step(word_type f, logic [15:0] r);
    logic [47:0] prod;
    logic [47:0] num;
    logic [47:0] q;
    logic [47:0] rm;
    prod = 48'(f) * 48'(r);
    num = ((prod + `RAT_HALF) >> `RAT_SHIFT) << `RAT_SHIFT;
    q = num / 48'(r);
    rm = num % 48'(r);
    rat_step = {q[31:0], rm[15:0]};
  endfunction
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic [47:0] step;
    logic [16:0] sum;
    step = '0;
    sum = '0;
    next_st = st;
    // every accumulator steps every cycle, selected or not
    for (int i = 0; i < 4; i++) begin
      if (resync_in) begin
        // resync puts all phases at a known origin
        next_st.acc[i] = '0;
        next_st.rem[i] = '0;
      end else if (rdiv_in == `RDIV_BASIC) begin
        // modulo-2^32 wrap, sign-agnostic word
        next_st.acc[i] = st.acc[i] + freq_in[i];
        next_st.rem[i] = '0;
      end else begin
        // exact fraction carried in a remainder mod divisor
        step = rat_step(freq_in[i], rdiv_in);
        sum = {1'b0, st.rem[i]} + {1'b0, step[15:0]};
        if (sum >= {1'b0, rdiv_in}) begin
          next_st.rem[i] = 16'(sum - {1'b0, rdiv_in});
          next_st.acc[i] = st.acc[i] + step[47:16] + 32'h0000_0001;
        end else begin
          next_st.rem[i] = sum[15:0];
          next_st.acc[i] = st.acc[i] + step[47:16];
        end
      end
    end
  end
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign acc_out = st.acc;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_basic_step: assert property (@(posedge clk_in) disable iff (srst_in)
    (rdiv_in == `RDIV_BASIC && !resync_in) |=>
    acc_out[2] == $past(acc_out[2]) + $past(freq_in[2]))
    else $error("basic step wrong");
  a_resync_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    resync_in |=> acc_out == '0)
    else $error("resync did not clear accumulators");
endmodule

// [core/nco_bank_select_sync.sv]
`timescale 1ns/1ns
`include "nco_defines.svh"
// ---------------------------------------------
// Summary of operation
// - four accumulators per channel, one per setting
// - all accumulators always run, coherent hopping
// - source bit 1: pins pick index
// - source bit 0 default: field picks index
// - own frequency and phase per accumulator
// - divisor zero: add 32-bit word each cycle
// - wraparound modulo 2^32, any number view
// - frequency rewrite: phase undefined until resync
// - nonzero divisor: exact rational step frequencies
// - phase word left-aligned, added to accumulator
// - resync on link init or on sysref
// - link-init sync sequence only with link enabled
// - sync low arms, sync high resynchronises
// - sync honoured even in 64b/66b modes
// - dc sysref: arm, then single pulse
// - running sysref: sync on next rising edge
// ---------------------------------------------
module nco_bank_select_sync
  import nco_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [1:0] chan_a_osc_select_pins_in,
  input wire logic [1:0] chan_b_osc_select_pins_in,
  input wire logic sync_single_ended_pin_n_in,
  input wire logic sysref_in,
  output logic [31:0] chan_a_phase_out,
  output logic [31:0] chan_b_phase_out,
  output logic [1:0] chan_a_active_out,
  output logic [1:0] chan_b_active_out,
  output logic resync_out
);
  // ---------------------------------------------
  // state and helpers
  // ---------------------------------------------
  top_state_type st; // all registered state
  top_state_type next_st; // next value of it
  logic [3:0][31:0] acc_a; // channel a accumulators
  logic [3:0][31:0] acc_b; // channel b accumulators
  logic ref_rise; // sysref rising edge
  logic fire_sync; // sync-pin resync event
  logic fire_ref; // sysref resync event
  // ---------------------------------------------
  // helper functions
  // ---------------------------------------------
  // phase of one selected accumulator plus its offset
  function automatic word_type add_offset(word_type acc,
                                          logic [15:0] ph);
    add_offset = acc + {ph, `PHASE_PAD};
  endfunction
  // status word seen by software
  function automatic word_type status_word(top_state_type s);
    status_word = '0;
    status_word[1:0] = s.act_a;
    status_word[3:2] = s.act_b;
    status_word[`STAT_NONDET_BIT] = s.nondet;
    status_word[`STAT_ARMED_BIT] = (s.fsm == SYNC_WAIT_HIGH);
  endfunction
  // read multiplexer; unmapped words read zero
  function automatic word_type read_mux(top_state_type s,
                                        logic [7:0] a);
    read_mux = '0;
    if (a == `ADDR_CTRL) begin
      read_mux = {24'h00_0000, s.ctrl};
    end else if (a == `ADDR_STATUS) begin
      read_mux = status_word(s);
    end else if (a == `ADDR_RDIV) begin
      read_mux = {16'h0000, s.rdiv};
    end else if (a[1:0] == 2'h0) begin
      unique case (a[7:4])
        `GRP_FREQ_A: read_mux = s.cfg_a.freq[a[3:2]];
        `GRP_FREQ_B: read_mux = s.cfg_b.freq[a[3:2]];
        `GRP_PHASE_A: read_mux = {16'h0000, s.cfg_a.phase[a[3:2]]};
        `GRP_PHASE_B: read_mux = {16'h0000, s.cfg_b.phase[a[3:2]]};
        default: read_mux = '0;
      endcase
    end
  endfunction
  // ---------------------------------------------
  // oscillator banks
  // ---------------------------------------------
  nco_bank bank_a (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .freq_in(st.cfg_a.freq),
    .rdiv_in(st.rdiv),
    .resync_in(st.resync),
    .acc_out(acc_a)
  );
  nco_bank bank_b (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .freq_in(st.cfg_b.freq),
    .rdiv_in(st.rdiv),
    .resync_in(st.resync),
    .acc_out(acc_b)
  );
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    next_st = st;
    fire_sync = 1'b0;
    // pins cross from outside through two flops each
    next_st.pin_a_s1 = chan_a_osc_select_pins_in;
    next_st.pin_a_s2 = st.pin_a_s1;
    next_st.pin_b_s1 = chan_b_osc_select_pins_in;
    next_st.pin_b_s2 = st.pin_b_s1;
    next_st.sync_s1 = sync_single_ended_pin_n_in;
    next_st.sync_s2 = st.sync_s1;
    next_st.ref_s1 = sysref_in;
    next_st.ref_s2 = st.ref_s1;
    next_st.ref_prev = st.ref_s2;
    ref_rise = st.ref_s2 && !st.ref_prev;
    // selection registered; accumulators untouched by it
    if (st.ctrl.src_pins) begin
      next_st.act_a = st.pin_a_s2;
      next_st.act_b = st.pin_b_s2;
    end else begin
      next_st.act_a = st.ctrl.sel_a;
      next_st.act_b = st.ctrl.sel_b;
    end
    // sync pin machine, same in 8b/10b and 64b/66b
    unique case (st.fsm)
      SYNC_IDLE: begin
        if (st.ctrl.sync_ila && st.ctrl.link_en) begin
          next_st.fsm = SYNC_WAIT_LOW;
        end
      end
      SYNC_WAIT_LOW: begin
        if (!(st.ctrl.sync_ila && st.ctrl.link_en)) begin
          next_st.fsm = SYNC_IDLE;
        end else if (!st.sync_s2) begin
          next_st.fsm = SYNC_WAIT_HIGH; // armed by low
        end
      end
      SYNC_WAIT_HIGH: begin
        if (!(st.ctrl.sync_ila && st.ctrl.link_en)) begin
          next_st.fsm = SYNC_IDLE;
        end else if (st.sync_s2) begin
          fire_sync = 1'b1; // high-going edge syncs
          next_st.fsm = SYNC_WAIT_LOW;
        end
      end
    endcase
    // armed sysref: first rising edge fires, arm self-clears
    fire_ref = st.ctrl.sync_next && ref_rise;
    if (fire_ref) begin
      next_st.ctrl.sync_next = 1'b0;
    end
    // either source restores a deterministic phase
    next_st.resync = fire_sync || fire_ref;
    if (next_st.resync) begin
      next_st.nondet = 1'b0;
    end
    // register writes come last so a set beats a clear
    if (wr_in) begin
      if (addr_in == `ADDR_CTRL) begin
        next_st.ctrl = ctrl_type'(wdata_in[7:0]);
      end else if (addr_in == `ADDR_RDIV) begin
        next_st.rdiv = wdata_in[15:0];
      end else if (addr_in[1:0] == 2'h0) begin
        // each accumulator has its own words
        unique case (addr_in[7:4])
          `GRP_FREQ_A: begin
            next_st.cfg_a.freq[addr_in[3:2]] = wdata_in;
            next_st.nondet = 1'b1;
          end
          `GRP_FREQ_B: begin
            next_st.cfg_b.freq[addr_in[3:2]] = wdata_in;
            next_st.nondet = 1'b1;
          end
          `GRP_PHASE_A: begin
            next_st.cfg_a.phase[addr_in[3:2]] = wdata_in[15:0];
          end
          `GRP_PHASE_B: begin
            next_st.cfg_b.phase[addr_in[3:2]] = wdata_in[15:0];
          end
          default: begin
            // unmapped group: keep whatever resync decided above
            next_st.nondet = next_st.nondet;
          end
        endcase
      end
    end
    // read data stand only in the cycle after the strobe
    next_st.rdata = rd_in ? read_mux(st, addr_in) : '0;
    // offset left-aligned onto the selected accumulator
    next_st.phase_a = add_offset(acc_a[st.act_a],
                                 st.cfg_a.phase[st.act_a]);
    next_st.phase_b = add_offset(acc_b[st.act_b],
                                 st.cfg_b.phase[st.act_b]);
  end
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.ctrl <= ctrl_type'(`CTRL_RESET);
      st.rdiv <= `RDIV_RESET;
      st.fsm <= SYNC_IDLE;
      // sync pin idles high so no false edge after reset
      st.sync_s1 <= 1'b1;
      st.sync_s2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign rdata_out = st.rdata;
  assign chan_a_phase_out = st.phase_a;
  assign chan_b_phase_out = st.phase_b;
  assign chan_a_active_out = st.act_a;
  assign chan_b_active_out = st.act_b;
  assign resync_out = st.resync;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_sel_pins_path: assert property (
    (st.ctrl.src_pins && !wr_in) |=> st.act_a == $past(st.pin_a_s2))
    else $error("pin selection not applied");
  a_sel_field_path: assert property (
    (!st.ctrl.src_pins && !wr_in) |=> st.act_b == $past(st.ctrl.sel_b))
    else $error("field selection not applied");
  a_phase_offset_sum: assert property (
    ##1 chan_a_phase_out == $past(acc_a[st.act_a])
      + {$past(st.cfg_a.phase[st.act_a]), 16'h0000})
    else $error("phase output wrong");
  a_sysref_fires_once: assert property (
    (st.ctrl.sync_next && st.ref_s2 && !st.ref_prev)
      |=> resync_out ##1 !resync_out)
    else $error("armed sysref did not resync once");
  a_arm_self_clear: assert property (
    (st.ctrl.sync_next && st.ref_s2 && !st.ref_prev && !wr_in)
      |=> !st.ctrl.sync_next)
    else $error("sysref arm not cleared");
  a_sync_high_fires: assert property (
    (st.fsm == SYNC_WAIT_HIGH && st.sync_s2 && st.ctrl.sync_ila
      && st.ctrl.link_en) |=> resync_out && st.fsm == SYNC_WAIT_LOW)
    else $error("sync rise did not resync");
  a_nondet_after_write: assert property (
    (wr_in && addr_in[7:4] == `GRP_FREQ_A && addr_in[1:0] == 2'h0)
      |=> st.nondet throughout (!resync_out [*2]))
    else $error("frequency write not flagged");
  a_read_one_later: assert property (
    (rd_in && addr_in == 8'h10)
      |=> rdata_out == $past(st.cfg_a.freq[0]))
    else $error("read data wrong");
  a_no_spurious_resync: assert property (
    (!st.ctrl.sync_next && st.fsm != SYNC_WAIT_HIGH) |=> !resync_out)
    else $error("resync without cause");
  c_hop_pins: cover property (
    st.ctrl.src_pins ##1 $changed(st.act_a));
  c_sync_path: cover property (
    st.fsm == SYNC_WAIT_HIGH ##1 resync_out);
  c_sysref_path: cover property (
    st.ctrl.sync_next ##[1:20] resync_out);
  c_rational: cover property (st.rdiv != 16'h0000 && !resync_out);
endmodule

// [verification/nco_link_rx_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------
// link receiver model: drives sync and sysref
// ----------------------------------------------
module nco_link_rx_model (
  input wire logic clk_in,
  output logic sync_n_out,
  output logic sysref_out
);
  int period = 0; // zero: sysref idles low
  int cnt = 0; // position inside the sysref period
  // sync stays deasserted (high) until a test asserts it
  initial sync_n_out = 1'b1;
  // dc sysref rests low between pulses
  initial sysref_out = 1'b0;
  // sync level changes just after an edge; low arms, high fires
  task automatic set_sync_n(input logic lvl);
    @(posedge clk_in);
    sync_n_out <= lvl;
  endtask
  // single pulse, four cycles wide so the 2-ff sync sees it
  task automatic sysref_pulse();
    @(posedge clk_in);
    sysref_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sysref_out <= 1'b0;
  endtask
  // long period leaves room to arm between edges
  task automatic run_sysref(input int p);
    @(posedge clk_in);
    #1 period = p;
  endtask
  // stop the free-running sysref and leave it low
  task automatic stop_sysref();
    @(posedge clk_in);
    #1 period = 0;
    @(posedge clk_in);
    sysref_out <= 1'b0;
  endtask
  // free-running sysref generator, 4 cycles high per period
  always @(posedge clk_in) begin
    if (period != 0) begin
      cnt <= (cnt + 1) % period;
      sysref_out <= (cnt < 4);
    end
  end
endmodule

// [verification/nco_bank_select_sync_tb.sv]
`timescale 1ns/1ns
`include "nco_defines.svh"
module nco_bank_select_sync_tb;
  // ----------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] pins_a = 2'h0; // channel a selection pins
  logic [1:0] pins_b = 2'h0; // channel b selection pins
  wire logic sync_n; // from the receiver model
  wire logic sysref; // from the receiver model
  logic [31:0] rdata_out;
  logic [31:0] phase_a;
  logic [31:0] phase_b;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic resync;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0; // timeout counter
  // 125 MHz sample clock
  always #4 clk_in = ~clk_in;
  nco_link_rx_model rx (
    .clk_in(clk_in),
    .sync_n_out(sync_n),
    .sysref_out(sysref)
  );
  nco_bank_select_sync DUT (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .chan_a_osc_select_pins_in(pins_a),
    .chan_b_osc_select_pins_in(pins_b),
    .sync_single_ended_pin_n_in(sync_n),
    .sysref_in(sysref),
    .chan_a_phase_out(phase_a),
    .chan_b_phase_out(phase_b),
    .chan_a_active_out(act_a),
    .chan_b_active_out(act_b),
    .resync_out(resync)
  );
  // ----------------------------------------------
  // shared tasks
  // ----------------------------------------------
  task automatic report_and_stop();
    $display("TB: %0d mismatches, %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // settle just after an edge, n edges on
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // bounded wait for the resync pulse; n == lim means none
  task automatic wait_resync(input int lim, output int n);
    n = 0;
    while (resync !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask
  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    rd(`ADDR_CTRL, v);
    check("ctrl reset", v, 32'h0000_0000);
    wr(`ADDR_RDIV, 32'h0000_1234);
    rd(`ADDR_RDIV, v);
    check("rdiv rw", v, 32'h0000_1234);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, v);
    check("unmapped", v, 32'h0000_0000);
    wr(`ADDR_RDIV, 32'h0000_0000);
  endtask
  // every field code, then every pin code
  task automatic t_select();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      pins_a <= 2'(3 - i); // pins must be ignored here
      pins_b <= 2'(i);
      wr(`ADDR_CTRL, 32'((i << 1) | ((3 - i) << 3)));
      step(4);
      check("field a", 32'(act_a), 32'(i));
      check("field b", 32'(act_b), 32'(3 - i));
    end
    wr(`ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      pins_a <= 2'(i);
      pins_b <= 2'(3 - i);
      step(5);
      check("pins a", 32'(act_a), 32'(i));
      check("pins b", 32'(act_b), 32'(3 - i));
    end
    wr(`ADDR_CTRL, 32'h0000_0000);
    step(4);
    check("pins ignored", 32'(act_a), 32'h0);
  endtask
  // channels start misaligned; one sysref pulse aligns them
  task automatic t_sysref();
    logic [31:0] v;
    int n;
    wr({`GRP_FREQ_A, 4'h0}, 32'h0000_0100);
    wr({`GRP_FREQ_B, 4'h0}, 32'h0000_0100);
    wr({`GRP_PHASE_B, 4'h0}, 32'h0000_4000);
    rd(`ADDR_STATUS, v);
    check("nondet set", 32'(v[`STAT_NONDET_BIT]), 32'h1);
    check("unsynced", 32'(phase_b - phase_a == 32'h4000_0000), 32'h0);
    wr(`ADDR_CTRL, 32'h0000_0040);
    fork
      rx.sysref_pulse();
      wait_resync(12, n);
    join
    check("sysref resync", 32'(n < 12), 32'h1);
    step(3);
    check("synced", phase_b - phase_a, 32'h4000_0000);
    rd(`ADDR_CTRL, v);
    check("arm clears", 32'(v[`CTRL_NEXT_BIT]), 32'h0);
    rd(`ADDR_STATUS, v);
    check("nondet clear", 32'(v[`STAT_NONDET_BIT]), 32'h0);
  endtask
  // step size, wraparound, hop and return, offset alignment
  task automatic t_accum();
    logic [31:0] p;
    p = phase_a;
    step(1);
    check("basic step", phase_a - p, 32'h0000_0100);
    wr({`GRP_FREQ_A, 4'h4}, 32'hFFFF_FFFF);
    wr(`ADDR_CTRL, 32'h0000_0002);
    step(4);
    p = phase_a;
    step(1);
    check("wrap step", phase_a - p, 32'hFFFF_FFFF);
    wr(`ADDR_CTRL, 32'h0000_0000);
    step(4);
    check("hop return", phase_b - phase_a, 32'h4000_0000);
    wr({`GRP_PHASE_A, 4'h0}, 32'h0000_0001);
    step(3);
    check("offset", phase_b - phase_a, 32'h3FFF_0000);
  endtask
  // divisor 3, one step: exactly 2^26 over three cycles
  task automatic t_rational();
    logic [31:0] p;
    wr(`ADDR_RDIV, 32'h0000_0003); // integer, below 8192
    wr({`GRP_FREQ_A, 4'h0}, 32'h0155_5555);
    step(4);
    p = phase_a;
    step(3);
    check("rational", phase_a - p, 32'h0400_0000);
    wr(`ADDR_RDIV, 32'h0000_0000);
  endtask
  task automatic t_sync_pin();
    logic [31:0] v;
    int n;
    wr(`ADDR_CTRL, 32'h0000_0020); // link off first
    wr({`GRP_FREQ_A, 4'h0}, 32'h0000_0100);
    rx.set_sync_n(1'b0);
    rx.set_sync_n(1'b1);
    wait_resync(10, n);
    check("no sync link off", 32'(n), 32'd10);
    wr(`ADDR_CTRL, 32'h0000_00A0);
    rx.set_sync_n(1'b0);
    step(6);
    rd(`ADDR_STATUS, v);
    check("sync armed", 32'(v[`STAT_ARMED_BIT]), 32'h1);
    rx.set_sync_n(1'b1);
    wait_resync(12, n);
    check("sync resync", 32'(n < 12), 32'h1);
    step(3);
    check("sync aligned", phase_b - phase_a, 32'h3FFF_0000);
    wr(`ADDR_CTRL, 32'h0000_0000);
  endtask
  // arm between two sysref edges, fire on the next one
  task automatic t_running();
    int n;
    rx.run_sysref(32);
    @(posedge sysref);
    step(4);
    wr(`ADDR_CTRL, 32'h0000_0040);
    wait_resync(60, n);
    check("next edge", 32'(n >= 16 && n < 40), 32'h1);
    rx.stop_sysref();
  endtask
  // ----------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_select();
    t_sysref();
    t_accum();
    t_rational();
    t_sync_pin();
    t_running();
    report_and_stop();
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("timeout after %0d cycles", cycles);
      report_and_stop();
    end
  end
endmodule
